// *** bench/flash_array_model.sv ***
// Purpose: Behavioural program flash array that records each command it receives.
// Assumes: One command pulse per operation; the array sends nothing back.
// Notes:   Cell contents are not kept; the bench judges the recorded command.
`timescale 1ns/1ps
module flash_array_model (
  // Clock.
  input  wire logic       mclk,
  // Command from the sequencer.
  input  wire logic       flashCmd,
  input  wire logic [3:0] flashOp,
  // Record for the bench.
  output logic      [7:0] nCmd,
  output logic      [3:0] seenOp
);
  logic [7:0] cmdCount_reg = 8'h00;
  logic [3:0] op_reg       = 4'h0;

  // Every pulse counts as a modification, so a pulse on a reserved code shows up.
  always @(posedge mclk) begin
    if (flashCmd === 1'b1) begin
      cmdCount_reg <= cmdCount_reg + 8'h01;
      op_reg       <= flashOp;
    end
  end

  assign nCmd   = cmdCount_reg;
  assign seenOp = op_reg;
endmodule : flash_array_model

// *** bench/flash_program_erase_control_test.sv ***
// Purpose: Self-checking bench for the flash program/erase control block.
// Assumes: Small operation and wake counts keep the run short.
// Notes:   The bench plays software and always writes source bit 0 as zero.
`timescale 1ns/1ps
module flash_program_erase_control_test;
  import flash_ctrl_pkg::*;
  localparam int OPN = 3;
  localparam int WKN = 4;
  logic        mclk     = 1'b0;
  logic        rstn     = 1'b0;
  logic        porRstn  = 1'b0;
  logic [2:0]  regAddr  = 3'h0;
  logic [15:0] regWdata = 16'h0000;
  logic        regWr    = 1'b0;
  logic        regRd    = 1'b0;
  logic        saveReq  = 1'b0;
  logic        idleExit = 1'b0;
  logic [15:0] regRdata;
  logic        grant, flashCmd, flashBusy, flashReady;
  logic [3:0]  flashOp, seenOp, op;
  logic [23:0] flashAddr, flashAddr2, sourceAddr, tgt, src, ea;
  logic [7:0]  flashKey, nCmd, nb, key;
  logic [15:0] d;
  logic [2:0]  a;
  logic [3:0]  ops [7] = '{4'he, 4'h3, 4'h2, 4'h1, 4'h0, 4'hf, 4'h7};
  int          fail_count = 0;
  int          n_compared = 0;
  int          seed = 32'hd98755d5;
  int          n, k;

  always #20 mclk = ~mclk;

  flash_program_erase_control #(.OP_CNT(OPN), .WAKE_CNT(WKN)) i_dut (
    .mclk(mclk), .rstn(rstn), .porRstn(porRstn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .powerSavingInstruction(saveReq), .idleExit(idleExit),
    .powerSaveGrant(grant), .flashCmd(flashCmd), .flashOp(flashOp),
    .flashAddr(flashAddr), .flashAddr2(flashAddr2), .sourceAddr(sourceAddr),
    .flashKey(flashKey), .flashBusy(flashBusy), .flashReady(flashReady));

  flash_array_model i_flash (
    .mclk(mclk), .flashCmd(flashCmd), .flashOp(flashOp), .nCmd(nCmd), .seenOp(seenOp));

  task automatic cmpReg(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmpReg

  task automatic cmpOut(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmpOut

  task automatic wr(input logic [2:0] ad, input logic [15:0] v);
    @(posedge mclk);
    regAddr  <= ad;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr    <= 1'b0;
  endtask : wr

  // Read data stand for one cycle only, so they are sampled just after that edge.
  task automatic rd(input logic [2:0] ad, input logic [15:0] m, input logic [15:0] exp);
    @(posedge mclk);
    regAddr <= ad;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd   <= 1'b0;
    #1;
    cmpReg(regRdata & m, exp);
  endtask : rd

  function automatic logic [15:0] expRead(input logic [2:0] ad, input logic [15:0] v);
    case (ad)
      TADDRL_IDX: return v;
      SADDRL_IDX: return v & 16'hfffe;
      TADDRH_IDX, SADDRH_IDX: return v & 16'h00ff;
      default: return 16'h0000;
    endcase
  endfunction : expRead

  task automatic end_sim;
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge mclk);
    rstn    <= 1'b1;
    porRstn <= 1'b1;
    rd(KEY_IDX, 16'hffff, 16'h0000);
    rd(CTRL_IDX, 16'h000f, {12'h000, OP_RESET});
    // The first pass writes all ones to indices 1 to 4 and 7, and all ones but bit 0 to index 5, to expose stuck upper bits.
    for (k = 0; k < 24; k++) begin
      a = (k % 6 == 5) ? 3'h7 : 3'(1 + k % 6);
      d = (k < 6) ? 16'hffff : 16'($random(seed));
      if (a == SADDRL_IDX) d[0] = 1'b0;
      wr(a, d);
      rd(a, 16'hffff, expRead(a, d));
    end
    for (k = 0; k < 7; k++) begin
      op  = ops[k];
      tgt = 24'($random(seed));
      src = 24'($random(seed));
      src[0] = 1'b0;
      key = 8'($random(seed));
      wr(TADDRH_IDX, {8'h00, tgt[23:16]});
      wr(TADDRL_IDX, tgt[15:0]);
      wr(SADDRH_IDX, {8'h00, src[23:16]});
      wr(SADDRL_IDX, src[15:0]);
      wr(KEY_IDX, {8'h00, key});
      wr(CTRL_IDX, {12'h000, op});
      rd(CTRL_IDX, 16'h000f, {12'h000, op});
      nb = nCmd;
      saveReq <= 1'b1;
      wr(CTRL_IDX, {12'h800, op});
      #1;
      n = 0;
      while (flashCmd !== 1'b1 && n < 4) begin
        @(posedge mclk);
        #1;
        n++;
      end
      if (k < 4) begin
        ea = (op == 4'h1) ? {tgt[23:1], 1'b0} : tgt;
        cmpOut({23'h0, flashCmd}, 24'h1);
        cmpOut({20'h0, flashOp}, {20'h0, op});
        cmpOut(flashAddr, ea);
        if (op == 4'h1) cmpOut(flashAddr2, ea | 24'h1);
        cmpOut(sourceAddr, src);
        cmpOut({16'h0, flashKey}, {16'h0, key});
        repeat (2) @(posedge mclk);
        #1;
        cmpOut({23'h0, grant}, 24'h0);
        n = 0;
        while (flashBusy !== 1'b0 && n < 20) begin
          @(posedge mclk);
          #1;
          n++;
        end
        repeat (2) @(posedge mclk);
        #1;
        cmpOut({23'h0, grant}, 24'h1);
        cmpOut({16'h0, nCmd}, {16'h0, nb + 8'h01});
        cmpOut({20'h0, seenOp}, {20'h0, op});
      end else begin
        cmpOut({23'h0, flashCmd}, 24'h0);
        cmpOut({16'h0, nCmd}, {16'h0, nb});
        rd(STATUS_IDX, 16'h0004, 16'h0004);
      end
      saveReq <= 1'b0;
    end
    // A system reset alone must keep the operation code; power-on clears it.
    wr(CTRL_IDX, 16'h0003);
    @(posedge mclk);
    rstn <= 1'b0;
    @(posedge mclk);
    rstn <= 1'b1;
    rd(CTRL_IDX, 16'h000f, 16'h0003);
    @(posedge mclk);
    rstn    <= 1'b0;
    porRstn <= 1'b0;
    @(posedge mclk);
    rstn    <= 1'b1;
    porRstn <= 1'b1;
    rd(CTRL_IDX, 16'h000f, 16'h0000);
    wr(CTRL_IDX, 16'h1000);
    @(posedge mclk);
    idleExit <= 1'b1;
    @(posedge mclk);
    idleExit <= 1'b0;
    @(posedge mclk);
    #1;
    cmpOut({23'h0, flashReady}, 24'h0);
    n = 0;
    while (flashReady !== 1'b1 && n < 30) begin
      @(posedge mclk);
      #1;
      n++;
    end
    cmpOut({23'h0, flashReady}, 24'h1);
    cmpOut({23'h0, n >= WKN}, 24'h1);
    wr(CTRL_IDX, 16'h0000);
    @(posedge mclk);
    idleExit <= 1'b1;
    @(posedge mclk);
    idleExit <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    cmpOut({23'h0, flashReady}, 24'h1);
    end_sim();
  end
endmodule : flash_program_erase_control_test

// *** design/cycle_timer.sv ***
// Purpose: Down-counter that raises done when a loaded count has elapsed.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   A load while running restarts the count.
`timescale 1ns/1ps
module cycle_timer #(
  parameter int CNT_W = 16
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             rstn,
  // Control.
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] count,
  // Status.
  output logic                  running,
  output logic                  done
);

  logic [CNT_W-1:0] cnt_reg;

  initial begin
    if (CNT_W < 2) $error("cycle_timer: CNT_W too small");
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_reg <= '0;
      running <= 1'b0;
      done    <= 1'b0;
    end else if (load) begin
      cnt_reg <= count;
      running <= 1'b1;
      done    <= 1'b0;
    end else if (running) begin
      cnt_reg <= cnt_reg - 1'b1;
      if (cnt_reg <= 1) begin
        running <= 1'b0;
        done    <= 1'b1;
      end
    end else begin
      done <= 1'b0;
    end
  end

endmodule : cycle_timer

// *** design/dword_align.sv ***
// Purpose: Forms the aligned word pair address for a double-word program.
// Assumes: Target addresses count words; two words sit inside a 4-word group.
// Notes:   Combinational; the caller registers the result.
`timescale 1ns/1ps
module dword_align (
  // Raw target.
  input  wire logic [23:0] target,
  // Aligned pair.
  output logic      [23:0] firstWord,
  output logic      [23:0] secondWord
);

  // Bit 0 is dropped so the pair never straddles a 4-word group.
  always_comb begin
    firstWord  = {target[23:1], 1'b0};
    secondWord = {target[23:1], 1'b1};
  end

endmodule : dword_align

// *** design/flash_program_erase_control.sv ***
// Purpose: Software-facing program/erase sequencer for the program flash.
// Assumes: Plain 16-bit register port; flash array accepts one command pulse.
// Notes:   Operation field survives every reset except power-on.
//
// Summary of operation
// (R1) Codes 1110 bulk erase, 0011 page erase, 0010 row program, 0001 double word; others reserved.
// (R2) A double-word program writes two adjacent words inside one 4-word aligned group.
// (R3) The operation field is cleared only by power-on reset.
// (R4) The power-saving instruction is ignored while any operation is in progress; the code grants one sent with a valid start in the first ST_RUN cycle.
// (R5) With stop-in-idle set, flash is unusable after idle until the regulator wake delay ends; a valid start in the idle-exit cycle skips the delay.
// (R6) The upper target register holds address bits 23 to 16 and is read/write.
// (R7) The lower target register holds address bits 15 to 0 and is read/write.
// (R8) The key register takes 8-bit writes, reads as zero and resets to zero.
// (R9) The upper source register holds data-memory address bits 23 to 16.
// (R10) The lower source register stores bits 15 to 1; bit 0 is held at zero.
// (R11) Bits 15 to 8 of the 8-bit registers ignore writes and read as zero.
// (R12) Starting with a reserved operation code modifies no flash.
`timescale 1ns/1ps
module flash_program_erase_control
  import flash_ctrl_pkg::*;
#(
  parameter int OP_CNT   = flash_ctrl_pkg::OP_CYCLES,
  parameter int WAKE_CNT = flash_ctrl_pkg::WAKE_CYCLES
) (
  // Clock and resets.
  input  wire logic                              mclk,
  input  wire logic                              rstn,
  input  wire logic                              porRstn,
  // Register port.
  input  wire logic [flash_ctrl_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [flash_ctrl_pkg::DATA_W-1:0] regWdata,
  input  wire logic                              regWr,
  input  wire logic                              regRd,
  output logic      [flash_ctrl_pkg::DATA_W-1:0] regRdata,
  // Power management.
  input  wire logic                              powerSavingInstruction,
  input  wire logic                              idleExit,
  output logic                                   powerSaveGrant,
  // Flash array side.
  output logic                                   flashCmd,
  output logic      [3:0]                        flashOp,
  output logic      [23:0]                       flashAddr,
  output logic      [23:0]                       flashAddr2,
  output logic      [23:0]                       sourceAddr,
  output logic      [7:0]                        flashKey,
  output logic                                   flashBusy,
  output logic                                   flashReady
);

  import flash_ctrl_pkg::*;

  initial begin
    if (OP_CNT < 1 || OP_CNT > 65535) $error("OP_CNT out of range");
    if (WAKE_CNT < 1 || WAKE_CNT > 65535) $error("WAKE_CNT out of range");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_WAKE = 2'b10
  } seq_state_e;

  seq_state_e  state_reg;
  logic [3:0]  flashOperationSelect_reg;
  logic        flashStopInIdle_reg;
  logic [7:0]  targetHigh_reg;
  logic [15:0] targetLow_reg;
  logic [7:0]  flashUnlockKey_reg;
  logic [7:0]  sourceHigh_reg;
  logic [15:1] sourceLow_reg;
  logic        reject_reg;
  logic        startReq;
  logic        validStart;
  logic        timerLoad;
  logic [15:0] timerCount;
  logic        timerRunning;
  logic        timerDone;
  logic [23:0] pairFirst;
  logic [23:0] pairSecond;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
    return a == idx;
  endfunction : hit

  assign startReq = regWr && hit(regAddr, CTRL_IDX) && regWdata[CTRL_START_BIT];
  // A reserved start may meet an idle exit in one cycle; only a valid start
  // may then be taken for a command, the wake load must not be.
  assign validStart = startReq && (state_reg == ST_IDLE) && opIsValid(flashOperationSelect_reg);

  // Operation field lives on the power-on reset only.
  always_ff @(posedge mclk) begin
    if (!porRstn) begin
      flashOperationSelect_reg <= OP_RESET; // R3
    end else if (regWr && hit(regAddr, CTRL_IDX) && state_reg == ST_IDLE) begin
      flashOperationSelect_reg <= regWdata[CTRL_OP_LSB +: CTRL_OP_W];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flashStopInIdle_reg <= 1'b0;
    end else if (regWr && hit(regAddr, CTRL_IDX)) begin
      flashStopInIdle_reg <= regWdata[CTRL_SIDL_BIT];
    end
  end

  // Address and key registers; upper bytes of the 8-bit registers are not stored.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      targetHigh_reg     <= 8'h00;
      targetLow_reg      <= ZERO16;
      flashUnlockKey_reg <= KEY_RESET; // R8
      sourceHigh_reg     <= 8'h00;
      sourceLow_reg      <= 15'h0000;
    end else if (regWr) begin
      if (hit(regAddr, TADDRH_IDX)) targetHigh_reg <= regWdata[7:0]; // R6 R11
      if (hit(regAddr, TADDRL_IDX)) targetLow_reg <= regWdata; // R7
      if (hit(regAddr, KEY_IDX)) flashUnlockKey_reg <= regWdata[7:0]; // R8
      if (hit(regAddr, SADDRH_IDX)) sourceHigh_reg <= regWdata[7:0]; // R9
      if (hit(regAddr, SADDRL_IDX)) sourceLow_reg <= regWdata[15:1]; // R10
    end
  end

  dword_align u_align (
    .target     ({targetHigh_reg, targetLow_reg}),
    .firstWord  (pairFirst),
    .secondWord (pairSecond)
  );

  // Sequencer: a valid start runs the op timer; idle exit with stop-in-idle
  // holds the flash off for the regulator wake delay; a valid start in the same cycle wins.
  always_comb begin
    timerLoad  = 1'b0;
    timerCount = 16'(OP_CNT);
    if (state_reg == ST_IDLE && startReq && opIsValid(flashOperationSelect_reg)) begin
      timerLoad = 1'b1; // R12
    end else if (state_reg == ST_IDLE && idleExit && flashStopInIdle_reg) begin
      timerLoad  = 1'b1; // R5
      timerCount = 16'(WAKE_CNT);
    end
  end

  cycle_timer #(.CNT_W(16)) u_timer (
    .mclk    (mclk),
    .rstn    (rstn),
    .load    (timerLoad),
    .count   (timerCount),
    .running (timerRunning),
    .done    (timerDone)
  );

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (validStart) state_reg <= ST_RUN; // R12
          else if (timerLoad) state_reg <= ST_WAKE; // R5
        end
        ST_RUN:  if (timerDone) state_reg <= ST_IDLE;
        ST_WAKE: if (timerDone) state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      reject_reg <= 1'b0;
    end else if (startReq && !opIsValid(flashOperationSelect_reg)) begin
      reject_reg <= 1'b1; // R12
    end else if (regRd && hit(regAddr, STATUS_IDX)) begin
      reject_reg <= 1'b0;
    end
  end

  // Flash command outputs.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flashCmd   <= 1'b0;
      flashOp    <= OP_RESET;
      flashAddr  <= 24'h000000;
      flashAddr2 <= 24'h000000;
      sourceAddr <= 24'h000000;
      flashKey   <= KEY_RESET;
    end else begin
      flashCmd <= validStart; // R1 R12
      if (validStart) begin
        flashOp    <= flashOperationSelect_reg; // R1
        flashAddr  <= (flashOperationSelect_reg == OP_DWORD_PROG) ? pairFirst
                    : {targetHigh_reg, targetLow_reg}; // R2
        flashAddr2 <= pairSecond; // R2
        sourceAddr <= {sourceHigh_reg, sourceLow_reg, 1'b0}; // R10
        flashKey   <= flashUnlockKey_reg;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flashBusy      <= 1'b0;
      flashReady     <= 1'b1;
      powerSaveGrant <= 1'b0;
    end else begin
      flashBusy      <= (state_reg == ST_RUN) || validStart;
      flashReady     <= (state_reg == ST_IDLE) && !timerLoad;
      powerSaveGrant <= powerSavingInstruction && state_reg != ST_RUN && !flashBusy; // R4
    end
  end

  // Read data one cycle after the strobe; key contents never read back.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      regRdata <= ZERO16;
    end else if (regRd) begin
      case (regAddr)
        CTRL_IDX:   regRdata <= {(state_reg == ST_RUN), 2'b00, flashStopInIdle_reg,
                                 8'h00, flashOperationSelect_reg};
        TADDRH_IDX: regRdata <= {8'h00, targetHigh_reg}; // R11
        TADDRL_IDX: regRdata <= targetLow_reg;
        KEY_IDX:    regRdata <= ZERO16; // R8
        SADDRH_IDX: regRdata <= {8'h00, sourceHigh_reg};
        SADDRL_IDX: regRdata <= {sourceLow_reg, 1'b0}; // R10
        STATUS_IDX: regRdata <= {13'h0000, reject_reg, (state_reg == ST_IDLE),
                                 (state_reg == ST_RUN)};
        default:    regRdata <= ZERO16;
      endcase
    end else begin
      regRdata <= ZERO16;
    end
  end

  chk_psave_blocked: assert property (@(posedge mclk) disable iff (!rstn)
    state_reg == ST_RUN |=> !powerSaveGrant) // R4
    else $error("power save granted during operation");
  chk_reserved_noop: assert property (@(posedge mclk) disable iff (!rstn)
    (state_reg == ST_IDLE && startReq && !opIsValid(flashOperationSelect_reg)) |=> !flashCmd) // R12
    else $error("flash command for reserved code");
  chk_valid_start: assert property (@(posedge mclk) disable iff (!rstn)
    (state_reg == ST_IDLE && startReq && opIsValid(flashOperationSelect_reg))
      |=> flashCmd && flashOp == $past(flashOperationSelect_reg)) // R1
    else $error("valid start not issued");
  chk_dword_pair: assert property (@(posedge mclk) disable iff (!rstn)
    flashCmd && flashOp == OP_DWORD_PROG |-> flashAddr[0] == 1'b0
      && flashAddr2 == flashAddr + 24'h000001) // R2
    else $error("double word pair misaligned");
  chk_op_keeps: assert property (@(posedge mclk) disable iff (!porRstn)
    !rstn && !(regWr && hit(regAddr, CTRL_IDX)) |=> $stable(flashOperationSelect_reg)) // R3
    else $error("operation field lost on system reset");
  chk_wake_hold: assert property (@(posedge mclk) disable iff (!rstn)
    (state_reg == ST_IDLE && idleExit && flashStopInIdle_reg && !startReq)
      |=> !flashReady [*2]) // R5
    else $error("flash ready before wake delay");
  chk_key_reads: assert property (@(posedge mclk) disable iff (!rstn)
    regRd && regAddr == KEY_IDX |=> regRdata == ZERO16) // R8
    else $error("key readable");
  chk_high_zero: assert property (@(posedge mclk) disable iff (!rstn)
    regRd && (regAddr == TADDRH_IDX || regAddr == SADDRH_IDX) |=> regRdata[15:8] == 8'h00) // R11
    else $error("upper byte not zero");
  chk_src_lsb: assert property (@(posedge mclk) disable iff (!rstn)
    regRd && regAddr == SADDRL_IDX |=> regRdata[0] == 1'b0) // R10
    else $error("source bit 0 set");
  chk_tlow_rw: assert property (@(posedge mclk) disable iff (!rstn)
    regWr && regAddr == TADDRL_IDX ##1 regRd && regAddr == TADDRL_IDX
      |=> regRdata == $past(regWdata, 2)) // R7
    else $error("lower target readback");
  chk_thigh_rw: assert property (@(posedge mclk) disable iff (!rstn)
    regWr && regAddr == TADDRH_IDX ##1 regRd && regAddr == TADDRH_IDX
      |=> regRdata[7:0] == $past(regWdata[7:0], 2)) // R6
    else $error("upper target readback");
  chk_shigh_rw: assert property (@(posedge mclk) disable iff (!rstn)
    regWr && regAddr == SADDRH_IDX ##1 regRd && regAddr == SADDRH_IDX
      |=> regRdata[7:0] == $past(regWdata[7:0], 2)) // R9
    else $error("upper source readback");

  cov_dword: cover property (@(posedge mclk) flashCmd && flashOp == OP_DWORD_PROG);
  cov_erase: cover property (@(posedge mclk) flashCmd && flashOp == OP_BULK_ERASE);
  cov_reject: cover property (@(posedge mclk) startReq && !opIsValid(flashOperationSelect_reg));
  cov_wake: cover property (@(posedge mclk) state_reg == ST_WAKE);

endmodule : flash_program_erase_control

// *** include/flash_ctrl_pkg.sv ***
// Purpose: Shared constants for the flash program/erase control block.
// Assumes: 16-bit register port, 25 MHz system clock.
// Notes:   Register indices are word indices on the plain register port.
package flash_ctrl_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;

  // Register indices.
  localparam logic [2:0] CTRL_IDX    = 3'h0;
  localparam logic [2:0] TADDRH_IDX  = 3'h1;
  localparam logic [2:0] TADDRL_IDX  = 3'h2;
  localparam logic [2:0] KEY_IDX     = 3'h3;
  localparam logic [2:0] SADDRH_IDX  = 3'h4;
  localparam logic [2:0] SADDRL_IDX  = 3'h5;
  localparam logic [2:0] STATUS_IDX  = 3'h6;

  // Control register fields.
  localparam int CTRL_START_BIT = 15;
  localparam int CTRL_SIDL_BIT  = 12;
  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_OP_W      = 4;

  // Status register fields.
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_READY_BIT  = 1;
  localparam int STAT_REJECT_BIT = 2;

  // Reset values.
  localparam logic [3:0]  OP_RESET  = 4'h0;
  localparam logic [7:0]  KEY_RESET = 8'h00;
  localparam logic [15:0] ZERO16    = 16'h0000;

  // Operation codes.
  typedef enum logic [3:0] {
    OP_BULK_ERASE  = 4'he,
    OP_PAGE_ERASE  = 4'h3,
    OP_ROW_PROGRAM = 4'h2,
    OP_DWORD_PROG  = 4'h1
  } flash_op_e;

  // Timing.
  localparam int CLK_HZ          = 25_000_000;
  localparam int OP_TIME_NS      = 2_000;
  localparam int OP_CYCLES       = (OP_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int WAKE_TIME_NS    = 10_000;
  localparam int WAKE_CYCLES     = (WAKE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  function automatic logic opIsValid(input logic [3:0] op);
    return (op == OP_BULK_ERASE) || (op == OP_PAGE_ERASE) ||
           (op == OP_ROW_PROGRAM) || (op == OP_DWORD_PROG);
  endfunction : opIsValid

endpackage : flash_ctrl_pkg
